// ==== src/programming_trigger_handshake.sv ====
// start handshake, result pins, lamp and buzzer control
`timescale 1ns/1ps
module programming_trigger_handshake #(
  parameter int unsigned START_CYC = prog_trig_pkg::START_PULSE_CYC,
  parameter int unsigned BUTTON_CYC = prog_trig_pkg::START_PULSE_CYC,
  parameter int unsigned BLINK_CYC = prog_trig_pkg::BLINK_HALF_CYC,
  parameter int unsigned BEEP_LEN = prog_trig_pkg::BEEP_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_trigger_n_i,
  input wire logic manual_trigger_button_n_i,
  input wire logic prog_done_i,
  input wire logic prog_ok_i,
  output logic prog_start_o,
  output logic busy_n_o,
  output logic pass_indicator_n_o,
  output logic fail_indicator_n_o,
  output logic activity_lamp_o,
  output logic buzzer_o
);
  localparam int W = prog_trig_pkg::CNT_W;

  logic machine_hit;
  logic button_hit;
  logic start_req;
  logic offline;
  logic ok_latched;
  logic [W-1:0] blink_cnt;
  logic [W-1:0] beep_cnt;
  prog_trig_pkg::state_t state;
  logic start_take;

  // idle and done both accept a new start; every other state refuses it
  function automatic logic start_open(input prog_trig_pkg::state_t s);
    return (s == prog_trig_pkg::ST_IDLE) || (s == prog_trig_pkg::ST_DONE);
  endfunction

  // ****************************************************************
  // start qualification
  // ****************************************************************
  pulse_qualifier #(.MIN_CYC(START_CYC)) u_machine_q (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .level_n_i(start_trigger_n_i),
    .hit_o(machine_hit)
  );

  // the button is also width-qualified, which doubles as debounce
  pulse_qualifier #(.MIN_CYC(BUTTON_CYC)) u_button_q (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .level_n_i(manual_trigger_button_n_i),
    .hit_o(button_hit)
  );

  assign start_req = machine_hit | button_hit;
  // a start only counts when the sequencer can take it; busy and results follow it
  assign start_take = start_req && start_open(state);

  // ****************************************************************
  // run sequencer
  // ****************************************************************
  // starts outside idle/done are dropped, a run cannot be re-entered
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= prog_trig_pkg::ST_IDLE;
      offline <= 1'b0;
      ok_latched <= 1'b0;
      beep_cnt <= '0;
    end else begin
      case (state)
        prog_trig_pkg::ST_IDLE, prog_trig_pkg::ST_DONE: begin
          if (start_req) begin
            state <= prog_trig_pkg::ST_RUN;
            offline <= button_hit & ~machine_hit;
          end
        end
        prog_trig_pkg::ST_RUN: begin
          if (prog_done_i) begin
            ok_latched <= prog_ok_i;
            beep_cnt <= '0;
            // only a successful offline run beeps
            state <= (prog_ok_i && offline) ? prog_trig_pkg::ST_BEEP
                                            : prog_trig_pkg::ST_DONE;
          end
        end
        prog_trig_pkg::ST_BEEP: begin
          beep_cnt <= beep_cnt + 1'b1;
          if (beep_cnt == BEEP_LEN[W-1:0] - 1'b1) begin
            state <= prog_trig_pkg::ST_DONE;
          end
        end
        default: begin
          state <= prog_trig_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // handshake outputs
  // ****************************************************************
  // start strobe to the programming engine, one cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prog_start_o <= 1'b0;
    end else begin
      prog_start_o <= start_take;
    end
  end

  // busy low throughout the run; results cleared at start, set at completion
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_n_o <= 1'b1;
      pass_indicator_n_o <= 1'b1;
      fail_indicator_n_o <= 1'b1;
    end else begin
      busy_n_o <= !(state == prog_trig_pkg::ST_RUN && !prog_done_i) && !start_take;
      if (start_take) begin
        pass_indicator_n_o <= 1'b1;
        fail_indicator_n_o <= 1'b1;
      end else if (state == prog_trig_pkg::ST_RUN && prog_done_i) begin
        pass_indicator_n_o <= ~prog_ok_i;
        fail_indicator_n_o <= prog_ok_i;
      end
    end
  end

  // ****************************************************************
  // lamp and buzzer
  // ****************************************************************
  // lamp toggles each half period while an offline run is in progress
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      blink_cnt <= '0;
      activity_lamp_o <= 1'b0;
    end else if (state == prog_trig_pkg::ST_RUN && offline) begin
      if (blink_cnt == BLINK_CYC[W-1:0] - 1'b1) begin
        blink_cnt <= '0;
        activity_lamp_o <= ~activity_lamp_o;
      end else begin
        blink_cnt <= blink_cnt + 1'b1;
      end
    end else begin
      blink_cnt <= '0;
      // steady on after offline success, off after offline failure
      activity_lamp_o <= (state == prog_trig_pkg::ST_DONE) && offline && ok_latched;
    end
  end

  // buzzer mirrors the beep state one edge late, so it comes straight from a flop
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      buzzer_o <= 1'b0;
    end else begin
      buzzer_o <= (state == prog_trig_pkg::ST_BEEP);
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_run_ends;
    state == prog_trig_pkg::ST_RUN && prog_done_i;
  endsequence

  a_busy_during_run: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == prog_trig_pkg::ST_RUN && !prog_done_i) |=> !busy_n_o)
    else $error("busy not low during run");
  a_idle_busy_high: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == prog_trig_pkg::ST_IDLE && !start_req) |=> busy_n_o)
    else $error("busy low while idle");
  a_pass_on_ok: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_run_ends and prog_ok_i) |=> !pass_indicator_n_o && fail_indicator_n_o)
    else $error("pass not shown");
  a_fail_on_err: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_run_ends and !prog_ok_i) |=> !fail_indicator_n_o && pass_indicator_n_o)
    else $error("fail not shown");
  a_one_result: assert property (@(posedge clk_i) disable iff (rst_i)
    !(!pass_indicator_n_o && !fail_indicator_n_o))
    else $error("both results low");
  a_start_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == prog_trig_pkg::ST_RUN) |=> !prog_start_o)
    else $error("start taken during run");
  a_beep_ok_only: assert property (@(posedge clk_i) disable iff (rst_i)
    buzzer_o |-> offline && ok_latched)
    else $error("buzzer without offline success");
  a_lamp_off_fail: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == prog_trig_pkg::ST_DONE && !ok_latched) [*2] |-> !activity_lamp_o)
    else $error("lamp lit after failure");
  a_start_strobe: assert property (@(posedge clk_i) disable iff (rst_i)
    (button_hit && state == prog_trig_pkg::ST_IDLE) |=> prog_start_o ##1 !busy_n_o)
    else $error("start not issued");

  // a shown result stays put until a run ends or a new start is taken
  sequence s_result_held;
    !start_take && !(state == prog_trig_pkg::ST_RUN && prog_done_i);
  endsequence

  a_pass_held: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_result_held and !pass_indicator_n_o) |=> !pass_indicator_n_o)
    else $error("pass dropped early");
  a_fail_held: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_result_held and !fail_indicator_n_o) |=> !fail_indicator_n_o)
    else $error("fail dropped early");
  a_start_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    start_take |=> pass_indicator_n_o && fail_indicator_n_o && !busy_n_o)
    else $error("start did not clear results");
  // the beep shows one edge after the sequencer enters its beep state
  a_beep_on_ok: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_run_ends and (prog_ok_i && offline)) |=> ##1 buzzer_o)
    else $error("no beep after offline success");
  a_quiet_on_fail: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_run_ends and !prog_ok_i) |=> ##1 !buzzer_o)
    else $error("beep after failure");
  // the steady-lamp checks wait two samples so the registered lamp has settled; the toggle check looks one edge on
  a_lamp_on_ok: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == prog_trig_pkg::ST_DONE && offline && ok_latched) [*2] |-> activity_lamp_o)
    else $error("lamp dark after offline success");
  a_lamp_toggles: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == prog_trig_pkg::ST_RUN && offline && blink_cnt == BLINK_CYC[W-1:0] - 1'b1)
    |=> activity_lamp_o != $past(activity_lamp_o))
    else $error("lamp did not blink");
endmodule // programming_trigger_handshake

// ==== src/prog_trig_pkg.sv ====
// constants and types for the programming trigger handshake
// ****************************************************************
// ****************************************************************
package prog_trig_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned START_PULSE_MS = 100;
  localparam int unsigned START_PULSE_CYC = CLK_HZ / 1000 * START_PULSE_MS;
  localparam int unsigned BLINK_HALF_MS = 50;
  localparam int unsigned BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
  localparam int unsigned BEEP_MS = 200;
  localparam int unsigned BEEP_CYC = CLK_HZ / 1000 * BEEP_MS;
  localparam int unsigned CNT_W = 32;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RUN,
    ST_BEEP,
    ST_DONE
  } state_t;
endpackage

// ==== src/pulse_qualifier.sv ====
// low-pulse width qualifier for the start and button inputs
`timescale 1ns/1ps
module pulse_qualifier #(
  parameter int unsigned MIN_CYC = prog_trig_pkg::START_PULSE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic level_n_i,
  output logic hit_o
);
  logic [prog_trig_pkg::CNT_W-1:0] low_cnt;

  // count low cycles; one pulse once the low has lasted MIN_CYC
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_cnt <= '0;
      hit_o <= 1'b0;
    end else begin
      hit_o <= 1'b0;
      if (level_n_i) begin
        low_cnt <= '0;
      end else if (low_cnt < MIN_CYC[prog_trig_pkg::CNT_W-1:0]) begin
        low_cnt <= low_cnt + 1'b1;
        // fires once per low phase, so a long hold gives one start
        hit_o <= (low_cnt == MIN_CYC[prog_trig_pkg::CNT_W-1:0] - 1'b1);
      end
    end
  end
endmodule // pulse_qualifier

// ==== tb/machine_model.sv ====
// production machine model driving the active-low start trigger
`timescale 1ns/1ps
module machine_model #(
  parameter int unsigned LOW_CYC = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  output logic start_n_o
);
  logic [3:0] cnt;
  // one low pulse of LOW_CYC samples per go request; a request mid-pulse is dropped
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 4'h0;
    end else if (go_i && cnt == 4'h0) begin
      cnt <= 4'(LOW_CYC);
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
  end
  // line rests high whenever no run is being requested
  assign start_n_o = (cnt == 4'h0);
endmodule // machine_model

// ==== tb/testbench.sv ====
// self-checking bench for the programming trigger handshake
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic go = 1'b0;
  logic button_n = 1'b1;
  logic done = 1'b0;
  logic ok = 1'b0;
  logic start_n, pstart, busy_n, pass_n, fail_n, lamp, buzz;
  int fails = 0;
  int n_tests = 0;
  int starts = 0;
  // 250 MHz clock and a count of engine start pulses
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) if (pstart === 1'b1) starts++;
  machine_model #(.LOW_CYC(8)) i_machine_model (.clk_i(clk_i), .rst_i(rst_i), .go_i(go),
    .start_n_o(start_n));
  // short counts keep the run brief; expectations below use the same figures
  programming_trigger_handshake #(.START_CYC(8), .BUTTON_CYC(8), .BLINK_CYC(3), .BEEP_LEN(4))
    i_programming_trigger_handshake (.clk_i(clk_i), .rst_i(rst_i), .start_trigger_n_i(start_n),
    .manual_trigger_button_n_i(button_n), .prog_done_i(done), .prog_ok_i(ok),
    .prog_start_o(pstart), .busy_n_o(busy_n), .pass_indicator_n_o(pass_n),
    .fail_indicator_n_o(fail_n), .activity_lamp_o(lamp), .buzzer_o(buzz));
  task automatic chk(input string what, input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // bounded wait for the engine start pulse; running out ends the run
  task automatic wait_start();
    int i;
    for (i = 0; i < 40 && pstart !== 1'b1; i++) @(posedge clk_i) #1;
    if (pstart !== 1'b1) begin
      chk("start pulse timeout", pstart, 1'b1);
      wrap_up();
    end
  endtask
  // engine reports one result, then busy must lift one edge later
  task automatic end_run(input logic ok_v);
    @(posedge clk_i);
    done <= 1'b1;
    ok <= ok_v;
    @(posedge clk_i);
    done <= 1'b0;
    @(posedge clk_i) #1;
    chk("busy_n", busy_n, 1'b1);
  endtask
  task automatic press(input int n);
    @(posedge clk_i);
    button_n <= 1'b0;
    repeat (n) @(posedge clk_i);
    button_n <= 1'b1;
  endtask
  // a press one sample short of the qualifying width must not start a run
  task automatic short_press();
    int n;
    n = starts;
    press(7);
    repeat (6) @(posedge clk_i) #1;
    chk("short press start", starts == n, 1'b1);
    chk("busy_n", busy_n, 1'b1);
  endtask
  // machine run with a second request in mid-run that must be ignored
  task automatic machine_run(input logic ok_v);
    int n;
    @(posedge clk_i) go <= 1'b1;
    @(posedge clk_i) go <= 1'b0;
    wait_start();
    chk("busy_n", busy_n, 1'b0);
    chk("pass_n cleared", pass_n, 1'b1);
    chk("fail_n cleared", fail_n, 1'b1);
    @(posedge clk_i) go <= 1'b1;
    @(posedge clk_i) go <= 1'b0;
    // the accepted pulse is counted on the edge after it shows, so sample now
    n = starts;
    repeat (14) @(posedge clk_i) #1;
    chk("busy_n held", busy_n, 1'b0);
    chk("restart ignored", starts == n, 1'b1);
    end_run(ok_v);
    chk("pass_n", pass_n, !ok_v);
    chk("fail_n", fail_n, ok_v);
  endtask
  // offline run: blinking meanwhile, then buzzer and lamp by result
  task automatic offline_run(input logic ok_v);
    int i;
    int tog;
    int b;
    logic prev;
    tog = 0;
    b = 0;
    press(8);
    wait_start();
    for (i = 0; i < 12; i++) begin
      prev = lamp;
      @(posedge clk_i) #1;
      if (lamp !== prev) tog++;
    end
    chk("lamp blinking", tog >= 3, 1'b1);
    end_run(ok_v);
    // sample first: the beep starts in the very cycle end_run returns
    repeat (10) begin
      if (buzz === 1'b1) b++;
      @(posedge clk_i) #1;
    end
    chk("buzzer cycles", b == (ok_v ? 4 : 0), 1'b1);
    chk("lamp final", lamp, ok_v);
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    #1;
    chk("busy_n reset", busy_n, 1'b1);
    chk("pass_n reset", pass_n, 1'b1);
    chk("fail_n reset", fail_n, 1'b1);
    @(posedge clk_i) rst_i <= 1'b0;
    short_press();
    machine_run(1'b1);
    machine_run(1'b0);
    offline_run(1'b1);
    offline_run(1'b0);
    wrap_up();
  end
endmodule // testbench
